// ===== flash_cmd_monitor.sv
`timescale 1ns/1ns
module flash_cmd_monitor
	import flash_cmd_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire bus_wr_t wr_i,
	input wire logic [ADDR_W-1:0] rd_addr_i,
	input wire logic [DATA_W-1:0] status_o,
	input wire logic [1:0] out_sel_o,
	input wire logic busy_o,
	input wire logic prog_pulse_o,
	input wire logic [DATA_W-1:0] prog_data_o
);
	// Opcode of a taken write, zero on idle cycles so stale bus data never decodes
	wire logic [7:0] op = wr_i.we ? wr_i.data[7:0] : 8'h00;
	wire logic hit = wr_i.addr[22:19] == rd_addr_i[22:19];
	wire logic [5:0] err = status_o[5:0] & 6'h3a;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	a_reset_idle: assert property ($fell(rst_i) |-> status_o == 16'h0080 && !busy_o)
		else $error("bad state after reset");
	a_clear_busy: assert property (busy_o && op == 8'h50 |-> ##2 err == $past(err, 2))
		else $error("errors cleared while busy");
	a_sig_sel: assert property (op == 8'h90 && hit |-> ##[1:2] out_sel_o == 2'h2)
		else $error("no signature output");
	a_cfi_sel: assert property (op == 8'h98 && hit |-> ##[1:2] out_sel_o == 2'h3)
		else $error("no query output");
	a_status_sel: assert property (op == 8'h70 && hit && !busy_o |-> ##[1:2] out_sel_o == 2'h1)
		else $error("no status output");
	a_buffered_factory_program_busy: assert property ((op == 8'h80 && !busy_o) ##1 op == 8'hd0 |-> ##[1:2] busy_o)
		else $error("factory program not busy");
	a_buffered_factory_program_err: assert property ((op == 8'h80 && !busy_o) ##1 (wr_i.we && op != 8'hd0)
		|-> ##[1:2] err != 6'h00)
		else $error("bad factory confirm not flagged");
	a_pulse_data: assert property (prog_pulse_o |-> $past(wr_i.we) && prog_data_o == $past(wr_i.data))
		else $error("program data mismatch");
endmodule : flash_cmd_monitor
bind flash_command_decoder flash_cmd_monitor i_mon (.mclk_i(mclk_i), .rst_i(rst_i), .wr_i(wr_i),
	.rd_addr_i(rd_addr_i), .status_o(status_o), .out_sel_o(out_sel_o), .busy_o(busy_o),
	.prog_pulse_o(prog_pulse_o), .prog_data_o(prog_data_o));

// ===== flash_cmd_pkg.sv
package flash_cmd_pkg;

	// ---------------------------------------------------------------
	// Geometry
	// ---------------------------------------------------------------
	localparam int NUM_BANKS = 16;
	localparam int BANK_W = 4;
	localparam int ADDR_W = 23;
	localparam int BANK_LSB = 19;
	localparam int BLOCK_LSB = 16;
	localparam int DATA_W = 16;
	localparam int OP_W = 8;

	// ---------------------------------------------------------------
	// Opcodes
	// ---------------------------------------------------------------
	localparam logic [7:0] OP_READ_ARRAY = 8'hff;
	localparam logic [7:0] OP_PROG_A = 8'h10;
	localparam logic [7:0] OP_PROG_B = 8'h40;
	localparam logic [7:0] OP_BUF_PROG = 8'he8;
	localparam logic [7:0] OP_ERASE = 8'h20;
	localparam logic [7:0] OP_BUFFERED_FACTORY_PROGRAM = 8'h80;
	localparam logic [7:0] OP_BLANK = 8'hbc;
	localparam logic [7:0] OP_CONFIRM = 8'hd0;
	localparam logic [7:0] OP_BLANK_CONF = 8'hcb;
	localparam logic [7:0] OP_SUSPEND = 8'hb0;
	localparam logic [7:0] OP_READ_STATUS = 8'h70;
	localparam logic [7:0] OP_CLR_STATUS = 8'h50;
	localparam logic [7:0] OP_READ_SIG = 8'h90;
	localparam logic [7:0] OP_READ_CFI = 8'h98;

	// ---------------------------------------------------------------
	// Status bits
	// ---------------------------------------------------------------
	localparam int SR_READY = 7;
	localparam int SR_ERASE_ERR = 5;
	localparam int SR_PROG_ERR = 4;
	localparam int SR_SUSP = 2;
	localparam int SR_LOWEST = 0;
	localparam logic [7:0] SR_ERR_MASK = 8'h3a;
	localparam logic [7:0] SR_RESET = 8'h80;

	// Cycles the internal operation stays busy
	localparam int OP_TIME_NS = 100;
	localparam int CLK_NS = 10;
	localparam int OP_CYCLES = OP_TIME_NS / CLK_NS;
	localparam logic [7:0] OP_CYC = 8'(OP_CYCLES);

	typedef enum logic [3:0] {
		ST_READY = 4'h0,
		ST_SETUP = 4'h1,
		ST_BUSY = 4'h3,
		ST_SUSPEND = 4'h2,
		ST_BUFFERED_FACTORY_PROGRAM_SETUP = 4'h6,
		ST_BUFFERED_FACTORY_PROGRAM_BUSY = 4'h7,
		ST_BLANK_SETUP = 4'h5,
		ST_BUF_SETUP = 4'h4
	} command_decoder_state_t;

	typedef enum logic [1:0] {
		OUT_ARRAY = 2'h0,
		OUT_STATUS = 2'h1,
		OUT_SIG = 2'h2,
		OUT_CFI = 2'h3
	} out_sel_t;

	typedef struct packed {
		logic we;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} bus_wr_t;

	typedef struct packed {
		command_decoder_state_t st;
		out_sel_t out;
	} bank_t;

endpackage : flash_cmd_pkg

// ===== flash_command_decoder.sv
`timescale 1ns/1ns
module flash_command_decoder
	import flash_cmd_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire bus_wr_t wr_i,
	input wire logic [ADDR_W-1:0] rd_addr_i,
	output logic [DATA_W-1:0] status_o,
	output logic [1:0] out_sel_o,
	output logic busy_o,
	output logic prog_pulse_o,
	output logic [DATA_W-1:0] prog_data_o
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		bank_t [NUM_BANKS-1:0] bank;
		logic [7:0] sr;
		logic [7:0] cnt;
		logic [BANK_W-1:0] act_bank;
		logic active;
		logic [ADDR_W-BLOCK_LSB-1:0] first_blk;
		logic [1:0] out_sel;
		logic busy;
		logic prog;
		logic [DATA_W-1:0] pdata;
	} state_t;

	state_t s_r;
	state_t s_nxt;
	logic [BANK_W-1:0] wb;
	logic [BANK_W-1:0] rb;
	logic [7:0] op;
	logic [ADDR_W-BLOCK_LSB-1:0] wblk;

	assign wb = wr_i.addr[ADDR_W-1:BANK_LSB];
	assign rb = rd_addr_i[ADDR_W-1:BANK_LSB];
	assign op = wr_i.data[OP_W-1:0];
	assign wblk = wr_i.addr[ADDR_W-1:BLOCK_LSB];

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		command_decoder_state_t cur;
		cur = s_r.bank[wb].st;
		s_nxt = s_r;
		s_nxt.prog = 1'b0;
		// Finish the running operation
		// Only one operation runs at a time, so a single counter serves all banks
		if (s_r.active && s_r.bank[s_r.act_bank].st == ST_BUSY) begin
			if (s_r.cnt != 8'h00) begin
				s_nxt.cnt = s_r.cnt - 8'h01;
			end else begin
				s_nxt.active = 1'b0;
				s_nxt.bank[s_r.act_bank].st = ST_READY;
				s_nxt.sr[SR_READY] = 1'b1;
			end
		end
		if (wr_i.we) begin
			case (cur)
				ST_BUFFERED_FACTORY_PROGRAM_BUSY: begin
					if (wblk == s_r.first_blk) begin
						s_nxt.prog = 1'b1;
						s_nxt.pdata = wr_i.data;
					end else begin
						s_nxt.bank[wb].st = ST_READY;
						s_nxt.active = 1'b0;
						s_nxt.sr[SR_READY] = 1'b1;
					end
				end
				ST_BUFFERED_FACTORY_PROGRAM_SETUP: begin
					if (op == OP_CONFIRM) begin
						s_nxt.bank[wb].st = ST_BUFFERED_FACTORY_PROGRAM_BUSY;
						s_nxt.active = 1'b1;
						s_nxt.act_bank = wb;
						s_nxt.first_blk = wblk;
						s_nxt.sr[SR_READY] = 1'b0;
					end else begin
						s_nxt.bank[wb].st = ST_READY;
						s_nxt.sr[SR_PROG_ERR] = 1'b1;
						s_nxt.sr[SR_ERASE_ERR] = 1'b1;
					end
				end
				ST_BUF_SETUP: begin
					s_nxt.bank[wb].st = ST_BUSY;
					s_nxt.active = 1'b1;
					s_nxt.act_bank = wb;
					s_nxt.cnt = OP_CYC;
					s_nxt.sr[SR_READY] = 1'b0;
					if (wblk != s_r.first_blk) begin
						s_nxt.sr[SR_PROG_ERR] = 1'b1;
					end
					s_nxt.prog = 1'b1;
					s_nxt.pdata = wr_i.data;
				end
				ST_SETUP, ST_BLANK_SETUP: begin
					if (cur == ST_BLANK_SETUP && op != OP_BLANK_CONF) begin
						s_nxt.bank[wb].st = ST_READY;
						s_nxt.sr[SR_ERASE_ERR] = 1'b1;
					end else begin
						s_nxt.bank[wb].st = ST_BUSY;
						s_nxt.active = 1'b1;
						s_nxt.act_bank = wb;
						s_nxt.cnt = OP_CYC;
						s_nxt.sr[SR_READY] = 1'b0;
						s_nxt.prog = 1'b1;
						s_nxt.pdata = wr_i.data;
					end
				end
				default: begin
					case (op)
						OP_READ_ARRAY: begin
							s_nxt.bank[wb].out = OUT_ARRAY;
						end
						OP_READ_STATUS: s_nxt.bank[wb].out = OUT_STATUS;
						OP_READ_SIG: s_nxt.bank[wb].out = OUT_SIG;
						OP_READ_CFI: s_nxt.bank[wb].out = OUT_CFI;
						OP_CLR_STATUS: begin
							if (!s_r.active && cur != ST_SUSPEND) begin
								s_nxt.sr = s_r.sr & ~SR_ERR_MASK;
							end
						end
						OP_SUSPEND: begin
							if (cur == ST_BUSY) begin
								s_nxt.bank[wb].st = ST_SUSPEND;
								s_nxt.sr[SR_SUSP] = 1'b1;
								s_nxt.sr[SR_READY] = 1'b1;
							end
						end
						OP_CONFIRM: begin
							if (cur == ST_SUSPEND) begin
								s_nxt.bank[wb].st = ST_BUSY;
								s_nxt.sr[SR_SUSP] = 1'b0;
								s_nxt.sr[SR_READY] = 1'b0;
							end
						end
						OP_PROG_A, OP_PROG_B, OP_ERASE, OP_BLANK, OP_BUF_PROG, OP_BUFFERED_FACTORY_PROGRAM: begin
							if (!s_r.active) begin
								s_nxt.bank[wb].out = OUT_STATUS;
								s_nxt.first_blk = wblk;
								if (op == OP_BLANK) begin
									s_nxt.bank[wb].st = ST_BLANK_SETUP;
								end else if (op == OP_BUF_PROG) begin
									s_nxt.bank[wb].st = ST_BUF_SETUP;
								end else if (op == OP_BUFFERED_FACTORY_PROGRAM) begin
									if (!s_r.sr[SR_LOWEST]) begin
										s_nxt.bank[wb].st = ST_BUFFERED_FACTORY_PROGRAM_SETUP;
									end else begin
										s_nxt.sr[SR_PROG_ERR] = 1'b1;
									end
								end else begin
									s_nxt.bank[wb].st = ST_SETUP;
								end
							end
						end
						default: s_nxt.bank[wb].out = s_r.bank[wb].out;
					endcase
				end
			endcase
		end
		// Output select follows the next bank state so a mode change shows one cycle later
		s_nxt.out_sel = s_nxt.bank[rb].out;
		s_nxt.busy = s_nxt.active;
	end

	// ---------------------------------------------------------------
	// Notes
	// ---------------------------------------------------------------
	// Factory programming has no cycle limit: it ends only on a write to another block in the same bank.
	// Status bit zero is never set here, so the factory program refusal path stays idle.

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			s_r <= '0;
			s_r.sr <= SR_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	// All outputs come straight from the state register to avoid glitches
	assign status_o = {8'h00, s_r.sr};
	assign out_sel_o = s_r.out_sel;
	assign busy_o = s_r.busy;
	assign prog_pulse_o = s_r.prog;
	assign prog_data_o = s_r.pdata;

endmodule : flash_command_decoder

// ===== flash_host_model.sv
`timescale 1ns/1ns
module flash_host_model
	import flash_cmd_pkg::*;
(
	input wire logic mclk_i,
	output bus_wr_t wr_o
);
	initial wr_o = '0;
	// one bank
	// Callers keep both cycles of a pair in one bank; idle bus alternates between inverted and original last word
	task put(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input int n);
		@(negedge mclk_i);
		wr_o = '{1'b1, a, d};
		repeat (n) begin
			@(negedge mclk_i);
			wr_o = '{1'b0, ~wr_o.addr, ~wr_o.data};
		end
	endtask : put
endmodule : flash_host_model

// ===== testbench.sv
`timescale 1ns/1ns
module testbench;
	import flash_cmd_pkg::*;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [ADDR_W-1:0] rd_addr_i = '0;
	bus_wr_t wr;
	logic [DATA_W-1:0] status_o, prog_data_o;
	logic [1:0] out_sel_o;
	logic busy_o, prog_pulse_o;
	int n_fail = 0;
	int cmp_count = 0;
	flash_command_decoder i_flash_command_decoder (.mclk_i(mclk_i), .rst_i(rst_i), .wr_i(wr),
		.rd_addr_i(rd_addr_i), .status_o(status_o), .out_sel_o(out_sel_o), .busy_o(busy_o),
		.prog_pulse_o(prog_pulse_o), .prog_data_o(prog_data_o));
	flash_host_model i_flash_host_model (.mclk_i(mclk_i), .wr_o(wr));
	initial forever #5 mclk_i = ~mclk_i;
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task end_of_test;
		$display("mismatches %0d compares %0d", n_fail, cmp_count);
		if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_of_test
	task cmd(input logic [22:0] a, input logic [15:0] d, input int n);
		i_flash_host_model.put(a, d, n);
	endtask : cmd
	task wait_busy(input logic v);
		for (int i = 0; i < 40 && busy_o !== v; i++) @(negedge mclk_i);
		chk(16'(busy_o), 16'(v));
	endtask : wait_busy
	task err(input logic v);
		chk(16'((status_o & 16'h003a) != 16'h0000), 16'(v));
	endtask : err
	task t_reset;
		chk(status_o, 16'h0080);
		chk(16'(out_sel_o), 16'h0000);
	endtask : t_reset
	task t_reads;
		logic [7:0] op[4] = '{8'h70, 8'h90, 8'h98, 8'hff};
		for (int i = 0; i < 4; i++) begin
			cmd(23'h0, {8'h00, op[i]}, 3);
			chk(16'(out_sel_o), 16'((i + 1) % 4));
		end
	endtask : t_reads
	task t_ops;
		logic [15:0] s[4] = '{16'h0010, 16'h0040, 16'h0020, 16'h00bc};
		logic [15:0] c[4] = '{16'h5a5a, 16'h1234, 16'h00d0, 16'h00cb};
		for (int i = 0; i < 4; i++) begin
			cmd(23'h0, s[i], 0);
			cmd(23'h0, c[i], 1);
			wait_busy(1'b1);
			wait_busy(1'b0);
			chk(status_o, 16'h0080);
			if (i < 2) chk(prog_data_o, c[i]);
		end
	endtask : t_ops
	task t_ignore;
		cmd(23'h0, 16'h0040, 2);
		chk(16'(out_sel_o), 16'h0001);
		cmd(23'h0, 16'h1111, 1);
		wait_busy(1'b1);
		cmd(23'h0, 16'h0040, 0);
		cmd(23'h0, 16'h2222, 1);
		wait_busy(1'b0);
		cmd(23'h0, 16'h0000, 4);
		chk(16'(busy_o), 16'h0000);
		chk(prog_data_o, 16'h1111);
	endtask : t_ignore
	task t_clear;
		cmd(23'h0, 16'h00bc, 0);
		cmd(23'h0, 16'h0011, 2);
		err(1'b1);
		cmd(23'h0, 16'h0040, 0);
		cmd(23'h0, 16'h0055, 1);
		cmd(23'h0, 16'h0050, 2);
		err(1'b1);
		wait_busy(1'b0);
		cmd(23'h0, 16'h0050, 2);
		chk(status_o, 16'h0080);
		cmd(23'h0, 16'h0080, 0);
		cmd(23'h0, 16'h0011, 2);
		err(1'b1);
		cmd(23'h0, 16'h0050, 2);
	endtask : t_clear
	task t_buffered_factory_program;
		cmd(23'h0, 16'h0080, 0);
		cmd(23'h0, 16'h00d0, 1);
		wait_busy(1'b1);
		cmd(23'h000100, 16'h0070, 1);
		chk(16'(prog_pulse_o), 16'h0001);
		chk(prog_data_o, 16'h0070);
		chk(16'(busy_o), 16'h0001);
		cmd(23'h010000, 16'h0000, 1);
		wait_busy(1'b0);
	endtask : t_buffered_factory_program
	initial begin
		repeat (12) @(negedge mclk_i);
		rst_i = 1'b0;
		t_reset();
		t_reads();
		t_ops();
		t_ignore();
		t_clear();
		t_buffered_factory_program();
		end_of_test();
	end
	// Whole run needs well under 1000 cycles
	initial begin
		#50000;
		n_fail++;
		end_of_test();
	end
endmodule : testbench
